// *** shared/phy_cfg_pkg.sv ***
// Package with register map, field positions and timing constants of the PHY configuration block.
package phy_cfg_pkg;
    localparam logic [7:0] ADDR_CFG = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam int BIT_BYPASS_BLOCK_CODER = 15;
    localparam int BIT_BYPASS_SCRAMBLING = 14;
    localparam int BIT_BYPASS_SYMBOL_PATH = 13;
    localparam int BIT_FORCE_SIGNAL_DETECT = 12;
    localparam int BIT_COPPER_FIBER_SELECT = 10;
    localparam int BIT_FORCE_FAST_LINK = 7;
    localparam int BIT_AUTO_REDUCED_POWER = 4;
    localparam int BIT_PHY_FSM_RESET = 3;
    localparam int BIT_MGMT_PREAMBLE_SUPPRESS = 2;
    localparam int BIT_SLEEP = 1;
    localparam int BIT_REMOTE_LOOP_OUT = 0;
    localparam logic [15:0] CFG_RESET = 16'h0414;
    localparam logic [15:0] CFG_WRITE_MASK = 16'hfdff;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int FSM_RESET_NS = 100;
    localparam int CLK_PERIOD_NS = 5;
    localparam int FSM_RESET_CYCLES = (FSM_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FSM_CNT_W = 8;
    localparam logic [FSM_CNT_W-1:0] FSM_CNT_LAST = FSM_CNT_W'(FSM_RESET_CYCLES - 1);
    localparam logic [FSM_CNT_W-1:0] FSM_CNT_ZERO = 8'h00;
endpackage

// *** hw/phy_fsm_reset_gen.sv ***
// Timed pulse generator for the PHY state machine reset.
`timescale 1ns/1ps
`default_nettype none
module phy_fsm_reset_gen
    import phy_cfg_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_start,
    output logic o_active,
    output logic o_done
);
    typedef enum logic [1:0] {S_IDLE = 2'b01, S_RUN = 2'b10} rst_state_t;
    rst_state_t state_q;
    rst_state_t state_d;
    logic [FSM_CNT_W-1:0] cnt_q;
    wire at_last = (cnt_q == FSM_CNT_LAST);

    always_comb begin
        case (state_q)
            S_IDLE: state_d = i_start ? S_RUN : S_IDLE;
            S_RUN: state_d = at_last ? S_IDLE : S_RUN;
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= S_IDLE;
            cnt_q <= FSM_CNT_ZERO;
            o_done <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= (state_q == S_RUN && !at_last) ? cnt_q + 1'b1 : FSM_CNT_ZERO;
            o_done <= (state_q == S_RUN) && at_last;
        end
    end

    assign o_active = (state_q == S_RUN);
endmodule
`default_nettype wire

// *** hw/axil_wr_capture.sv ***
// Write channel capture for the AXI4-Lite slave, taking address and data in either order.
`timescale 1ns/1ps
`default_nettype none
module axil_wr_capture
    import phy_cfg_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_awvalid,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_bready,
    output logic o_awready,
    output logic o_wready,
    output logic o_bvalid,
    output logic [1:0] o_bresp,
    output logic o_wr_go,
    output logic [7:0] o_wr_addr,
    output logic [31:0] o_wr_data,
    output logic [3:0] o_wr_strb
);
    logic have_a_q;
    logic have_w_q;
    wire a_take = i_awvalid && o_awready;
    wire w_take = i_wvalid && o_wready;
    wire a_full = have_a_q || a_take;
    wire w_full = have_w_q || w_take;
    wire go = a_full && w_full && !o_bvalid;
    wire [7:0] addr_now = a_take ? i_awaddr : o_wr_addr;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            have_a_q <= 1'b0;
            have_w_q <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
            o_wr_go <= 1'b0;
            o_wr_addr <= 8'h00;
            o_wr_data <= 32'h0000_0000;
            o_wr_strb <= 4'h0;
        end else begin
            if (a_take) begin
                o_wr_addr <= i_awaddr;
            end
            if (w_take) begin
                o_wr_data <= i_wdata;
                o_wr_strb <= i_wstrb;
            end
            have_a_q <= a_full && !go;
            have_w_q <= w_full && !go;
            o_awready <= !a_full || go ? (o_bvalid ? 1'b0 : !a_full) : 1'b0;
            o_wready <= !w_full || go ? (o_bvalid ? 1'b0 : !w_full) : 1'b0;
            o_wr_go <= go;
            if (go) begin
                o_bvalid <= 1'b1;
                o_bresp <= (addr_now == ADDR_CFG || addr_now == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
                o_awready <= 1'b1;
                o_wready <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** hw/phy_specific_config.sv ***
// PHY specific configuration register with its AXI4-Lite slave and control outputs.
//
// Notes on behaviour
// [R1]: Block coder bypass bit set skips 4B5B encoder and decoder; resets to 0.
// [R2]: Scrambling bypass bit set bypasses scrambler and descrambler; resets to 0.
// [R3]: Symbol path bypass bit set bypasses alignment, coding and scrambling paths; o_bypass_block_coder ignores it and follows bit 15 only.
// [R4]: Forced signal detect makes the detector read active; debug only, resets 0.
// [R5]: Software always writes 0 to reserved read-write bits 11, 8, 6, 5.
// [R6]: Copper/fiber select: 1 copper TX, 0 fiber FX; resets to 1.
// [R7]: Force fast link reports good 100 Mbps link regardless of line; resets 0.
// [R8]: Auto reduced power enable permits automatic reduced power-down; resets to 1.
// [R9]: Writing 1 to FSM reset resets all PHY state machines; 0 ignored.
// [R10]: FSM reset bit clears itself once the state machine reset completes.
// [R11]: Management preamble suppression on when 1, off when 0; resets to 1.
// [R12]: Writing 1 to sleep powers down all but oscillator and clock generator.
// [R13]: Leaving sleep keeps configuration but restarts state machines from reset.
// [R14]: Remote loop-out set routes received data back to transmit; resets to 0.
// [R15]: Reserved bit 9 reads 0 and ignores writes.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module phy_specific_config
    import phy_cfg_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_awvalid,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_bready,
    input wire logic i_arvalid,
    input wire logic [7:0] i_araddr,
    input wire logic i_rready,
    input wire logic i_line_signal_detect,
    input wire logic i_line_link_good,
    output logic o_awready,
    output logic o_wready,
    output logic o_bvalid,
    output logic [1:0] o_bresp,
    output logic o_arready,
    output logic o_rvalid,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_bypass_block_coder,
    output logic o_bypass_scrambling,
    output logic o_bypass_symbol_path,
    output logic o_signal_detector,
    output logic o_copper_fiber_select,
    output logic o_link_good_100,
    output logic o_auto_reduced_power_enable,
    output logic o_phy_fsm_reset,
    output logic o_mgmt_preamble_suppress,
    output logic o_sleep,
    output logic o_remote_loop_out
);
    ////////////////////////////////////////////////////////////////////////////
    // Write path.
    logic wr_go;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [15:0] cfg_q;
    logic [15:0] cfg_d;
    logic rst_active;
    logic rst_done;
    logic wake_q;

    axil_wr_capture u_wr (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_awvalid(i_awvalid),
        .i_awaddr(i_awaddr),
        .i_wvalid(i_wvalid),
        .i_wdata(i_wdata),
        .i_wstrb(i_wstrb),
        .i_bready(i_bready),
        .o_awready(o_awready),
        .o_wready(o_wready),
        .o_bvalid(o_bvalid),
        .o_bresp(o_bresp),
        .o_wr_go(wr_go),
        .o_wr_addr(wr_addr),
        .o_wr_data(wr_data),
        .o_wr_strb(wr_strb)
    );

    function automatic logic [15:0] merge_lanes(input logic [15:0] old, input logic [15:0] nw,
                                                input logic [1:0] strb);
        merge_lanes = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
    endfunction

    wire cfg_hit = wr_go && (wr_addr == ADDR_CFG);
    wire [15:0] merged = merge_lanes(cfg_q, wr_data[15:0], wr_strb[1:0]) & CFG_WRITE_MASK; // [R15]
    wire fsm_req_wr = cfg_hit && wr_strb[0] && wr_data[BIT_PHY_FSM_RESET]; // [R9]
    wire sleep_wr = cfg_hit && wr_strb[0];
    wire wake_event = sleep_wr && cfg_q[BIT_SLEEP] && !wr_data[BIT_SLEEP]; // [R13]

    // Only a written 1 sets the reset bit and only completion clears it, so a stray 0 cannot cut it short.
    always_comb begin
        cfg_d = cfg_hit ? merged : cfg_q;
        cfg_d[BIT_PHY_FSM_RESET] = fsm_req_wr | (cfg_q[BIT_PHY_FSM_RESET] & !rst_done); // [R9] [R10]
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cfg_q <= CFG_RESET;
            wake_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            wake_q <= wake_event;
        end
    end

    // Waking from sleep retains configuration but pulses a full state machine reset.
    phy_fsm_reset_gen u_rst (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_start(fsm_req_wr || wake_q), // [R9] [R13]
        .o_active(rst_active),
        .o_done(rst_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read path.
    wire rd_take = i_arvalid && o_arready;
    wire rd_cfg = (i_araddr == ADDR_CFG);
    wire rd_stat = (i_araddr == ADDR_STATUS);
    wire [31:0] stat_word = {29'h0, o_sleep, o_link_good_100, rst_active};

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_arready <= 1'b1;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= RESP_OKAY;
        end else if (rd_take) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= rd_cfg ? {16'h0000, cfg_q} : (rd_stat ? stat_word : 32'h0000_0000);
            o_rresp <= (rd_cfg || rd_stat) ? RESP_OKAY : RESP_SLVERR;
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control outputs, registered from the configuration word, the line inputs and the reset generator.
    // Reserved bits 11, 8, 6 and 5 are stored but steer nothing, so a stray 1 is harmless.
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_bypass_block_coder <= 1'b0;
            o_bypass_scrambling <= 1'b0;
            o_bypass_symbol_path <= 1'b0;
            o_signal_detector <= 1'b0;
            o_copper_fiber_select <= 1'b1;
            o_link_good_100 <= 1'b0;
            o_auto_reduced_power_enable <= 1'b1;
            o_phy_fsm_reset <= 1'b0;
            o_mgmt_preamble_suppress <= 1'b1;
            o_sleep <= 1'b0;
            o_remote_loop_out <= 1'b0;
        end else begin
            o_bypass_block_coder <= cfg_q[BIT_BYPASS_BLOCK_CODER]; // [R1]
            // Symbol path bypass also bypasses the scrambler pair.
            o_bypass_scrambling <= cfg_q[BIT_BYPASS_SCRAMBLING] | cfg_q[BIT_BYPASS_SYMBOL_PATH]; // [R2] [R3]
            o_bypass_symbol_path <= cfg_q[BIT_BYPASS_SYMBOL_PATH]; // [R3]
            o_signal_detector <= cfg_q[BIT_FORCE_SIGNAL_DETECT] | i_line_signal_detect; // [R4]
            o_copper_fiber_select <= cfg_q[BIT_COPPER_FIBER_SELECT]; // [R6]
            o_link_good_100 <= cfg_q[BIT_FORCE_FAST_LINK] | i_line_link_good; // [R7]
            o_auto_reduced_power_enable <= cfg_q[BIT_AUTO_REDUCED_POWER]; // [R8]
            o_phy_fsm_reset <= rst_active; // [R9]
            o_mgmt_preamble_suppress <= cfg_q[BIT_MGMT_PREAMBLE_SUPPRESS]; // [R11]
            o_sleep <= cfg_q[BIT_SLEEP]; // [R12]
            o_remote_loop_out <= cfg_q[BIT_REMOTE_LOOP_OUT]; // [R14]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_block_coder;
        @(posedge i_mclk) disable iff (!i_reset_n) o_bypass_block_coder == $past(cfg_q[BIT_BYPASS_BLOCK_CODER]);
    endproperty
    a_block_coder: assert property (p_block_coder) else $error("Block coder bypass wrong."); // [R1]

    property p_scramble;
        @(posedge i_mclk) disable iff (!i_reset_n)
            $past(cfg_q[BIT_BYPASS_SCRAMBLING]) |-> o_bypass_scrambling;
    endproperty
    a_scramble: assert property (p_scramble) else $error("Scrambler bypass missing."); // [R2]

    property p_symbol;
        @(posedge i_mclk) disable iff (!i_reset_n)
            o_bypass_symbol_path |-> o_bypass_scrambling;
    endproperty
    a_symbol: assert property (p_symbol) else $error("Symbol bypass left scrambler on."); // [R3]

    property p_sd;
        @(posedge i_mclk) disable iff (!i_reset_n)
            $past(cfg_q[BIT_FORCE_SIGNAL_DETECT]) |-> o_signal_detector;
    endproperty
    a_sd: assert property (p_sd) else $error("Signal detect not forced."); // [R4]

    property p_link;
        @(posedge i_mclk) disable iff (!i_reset_n)
            $past(cfg_q[BIT_FORCE_FAST_LINK]) |-> o_link_good_100;
    endproperty
    a_link: assert property (p_link) else $error("Fast link not forced."); // [R7]

    property p_res9;
        @(posedge i_mclk) disable iff (!i_reset_n) cfg_q[9] == 1'b0;
    endproperty
    a_res9: assert property (p_res9) else $error("Reserved bit 9 set."); // [R15]

    sequence s_req;
        fsm_req_wr && !rst_active;
    endsequence
    sequence s_pulse;
        ##1 o_phy_fsm_reset [*8];
    endsequence
    property p_fsm;
        @(posedge i_mclk) disable iff (!i_reset_n) s_req |-> ##1 s_pulse;
    endproperty
    a_fsm: assert property (p_fsm) else $error("State machine reset pulse short."); // [R9]

    property p_selfclr;
        @(posedge i_mclk) disable iff (!i_reset_n)
            s_req |-> ##[1:40] !cfg_q[BIT_PHY_FSM_RESET];
    endproperty
    a_selfclr: assert property (p_selfclr) else $error("Reset bit did not clear."); // [R10]

    property p_wake;
        @(posedge i_mclk) disable iff (!i_reset_n)
            wake_event && !rst_active |-> ##[2:3] o_phy_fsm_reset;
    endproperty
    a_wake: assert property (p_wake) else $error("No reset on wake."); // [R13]

    property p_loop;
        @(posedge i_mclk) disable iff (!i_reset_n) o_remote_loop_out == $past(cfg_q[BIT_REMOTE_LOOP_OUT]);
    endproperty
    a_loop: assert property (p_loop) else $error("Loop out wrong."); // [R14]
endmodule
`default_nettype wire

// *** verif/axil_mgmt_master.sv ***
// Management master model that reads and writes the configuration block over its register bus.
`timescale 1ns/1ps
`default_nettype none
module axil_mgmt_master (
    input wire logic i_mclk,
    input wire logic i_awready,
    input wire logic i_wready,
    input wire logic i_bvalid,
    input wire logic [1:0] i_bresp,
    input wire logic i_arready,
    input wire logic i_rvalid,
    input wire logic [31:0] i_rdata,
    input wire logic [1:0] i_rresp,
    output var logic o_awvalid,
    output var logic [7:0] o_awaddr,
    output var logic o_wvalid,
    output var logic [31:0] o_wdata,
    output var logic [3:0] o_wstrb,
    output var logic o_bready,
    output var logic o_arvalid,
    output var logic [7:0] o_araddr,
    output var logic o_rready
);
    initial begin
        {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
        o_awaddr = 8'h00;
        o_araddr = 8'h00;
        o_wdata = 32'h0000_0000;
        o_wstrb = 4'h0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Released address and data lines carry the inverse of their last value, so a stale address never looks valid.
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s, output logic [1:0] r);
        @(posedge i_mclk);
        o_awvalid <= 1'b1;
        o_awaddr <= a;
        o_wvalid <= 1'b1;
        o_wdata <= {16'h0000, d};
        o_wstrb <= s;
        o_bready <= 1'b1;
        do begin
            @(posedge i_mclk);
            if (o_awvalid && i_awready) begin
                o_awvalid <= 1'b0;
                o_awaddr <= ~a;
            end
            if (o_wvalid && i_wready) begin
                o_wvalid <= 1'b0;
                o_wdata <= ~{16'h0000, d};
            end
        end while (i_bvalid !== 1'b1);
        r = i_bresp;
        o_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_mclk);
        o_arvalid <= 1'b1;
        o_araddr <= a;
        o_rready <= 1'b1;
        do begin
            @(posedge i_mclk);
            if (o_arvalid && i_arready) begin
                o_arvalid <= 1'b0;
                o_araddr <= ~a;
            end
        end while (i_rvalid !== 1'b1);
        d = i_rdata;
        r = i_rresp;
        o_rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** verif/phy_specific_config_tb.sv ***
// Self-checking testbench of the PHY specific configuration register.
`timescale 1ns/1ps
`default_nettype none
module phy_specific_config_tb;
    import phy_cfg_pkg::*;
    logic i_mclk;
    logic i_reset_n;
    logic line_sd;
    logic line_lg;
    logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_q;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp_q;
    logic bbc, bsc, bsp, sdet, cfs, lg100, arpe, fsmr, mps, slp, rlo;
    int err_count = 0;
    int n_checks = 0;
    int pulse_cnt = 0;
    int cyc = 0;
    ////////////////////////////////////////////////////////////////////////////////
    phy_specific_config uut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_awvalid(awvalid), .i_awaddr(awaddr),
        .i_wvalid(wvalid), .i_wdata(wdata), .i_wstrb(wstrb), .i_bready(bready), .i_arvalid(arvalid),
        .i_araddr(araddr), .i_rready(rready), .i_line_signal_detect(line_sd), .i_line_link_good(line_lg),
        .o_awready(awready), .o_wready(wready), .o_bvalid(bvalid), .o_bresp(bresp), .o_arready(arready),
        .o_rvalid(rvalid), .o_rdata(rdata), .o_rresp(rresp), .o_bypass_block_coder(bbc),
        .o_bypass_scrambling(bsc), .o_bypass_symbol_path(bsp), .o_signal_detector(sdet),
        .o_copper_fiber_select(cfs), .o_link_good_100(lg100), .o_auto_reduced_power_enable(arpe),
        .o_phy_fsm_reset(fsmr), .o_mgmt_preamble_suppress(mps), .o_sleep(slp), .o_remote_loop_out(rlo));
    axil_mgmt_master mgr (.i_mclk(i_mclk), .i_awready(awready), .i_wready(wready), .i_bvalid(bvalid),
        .i_bresp(bresp), .i_arready(arready), .i_rvalid(rvalid), .i_rdata(rdata), .i_rresp(rresp),
        .o_awvalid(awvalid), .o_awaddr(awaddr), .o_wvalid(wvalid), .o_wdata(wdata), .o_wstrb(wstrb),
        .o_bready(bready), .o_arvalid(arvalid), .o_araddr(araddr), .o_rready(rready));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        if (fsmr === 1'b1) begin
            pulse_cnt++;
        end
    end
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    // Expected control levels; forced bits OR with the line inputs and the pulse is idle.
    task automatic chk_outs(input logic [15:0] c);
        chk({21'h0, bbc, bsc, bsp, sdet, cfs, lg100, arpe, fsmr, mps, slp, rlo},
            {21'h0, c[15], c[14] | c[13], c[13], c[12] | line_sd, c[10], c[7] | line_lg, c[4], 1'b0, c[2], c[1], c[0]});
    endtask
    task automatic rd_cfg(input logic [15:0] exp);
        mgr.rd(ADDR_CFG, rd_q, resp_q);
        chk(rd_q, {16'h0000, exp});
        chk({30'h0, resp_q}, {30'h0, RESP_OKAY});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk_outs(16'h0414);
        rd_cfg(16'h0414);
    endtask
    task automatic t_fields;
        logic [15:0] vals [9];
        vals = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0080, 16'h0010, 16'h0004, 16'h0001, 16'h0000};
        foreach (vals[i]) begin
            mgr.wr(ADDR_CFG, vals[i] | 16'h0200, 4'h3, resp_q);
            wait_cyc(3);
            chk_outs(vals[i]);
            rd_cfg(vals[i]);
        end
        chk(pulse_cnt, 0);
        @(posedge i_mclk);
        line_sd <= 1'b1;
        line_lg <= 1'b1;
        wait_cyc(3);
        chk_outs(16'h0000);
        mgr.rd(ADDR_STATUS, rd_q, resp_q);
        chk(rd_q, 32'h0000_0002);
        @(posedge i_mclk);
        line_sd <= 1'b0;
        line_lg <= 1'b0;
    endtask
    // Only the low byte lane is enabled, so the set upper byte must not land.
    task automatic t_fsm;
        pulse_cnt = 0;
        mgr.wr(ADDR_CFG, 16'hff08, 4'h1, resp_q);
        rd_cfg(16'h0008);
        mgr.wr(ADDR_CFG, 16'h0000, 4'h1, resp_q);
        rd_cfg(16'h0008);
        wait_cyc(40);
        chk(pulse_cnt, FSM_RESET_CYCLES);
        rd_cfg(16'h0000);
    endtask
    task automatic t_sleep;
        pulse_cnt = 0;
        mgr.wr(ADDR_CFG, 16'h4403, 4'h3, resp_q);
        wait_cyc(3);
        chk_outs(16'h4403);
        chk(pulse_cnt, 0);
        mgr.wr(ADDR_CFG, 16'h4401, 4'h3, resp_q);
        wait_cyc(40);
        chk_outs(16'h4401);
        rd_cfg(16'h4401);
        chk(pulse_cnt, FSM_RESET_CYCLES);
    endtask
    task automatic t_bus;
        mgr.wr(8'h48, 16'hffff, 4'h3, resp_q);
        chk({30'h0, resp_q}, {30'h0, RESP_SLVERR});
        mgr.wr(ADDR_STATUS, 16'h0000, 4'h3, resp_q);
        chk({30'h0, resp_q}, {30'h0, RESP_OKAY});
        mgr.rd(8'h48, rd_q, resp_q);
        chk(rd_q, 32'h0000_0000);
        chk({30'h0, resp_q}, {30'h0, RESP_SLVERR});
        rd_cfg(16'h4401);
        mgr.wr(ADDR_CFG, 16'h80ff, 4'h2, resp_q);
        wait_cyc(30);
        rd_cfg(16'h8001);
        chk(pulse_cnt, FSM_RESET_CYCLES);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_reset_n = 1'b0;
        line_sd = 1'b0;
        line_lg = 1'b0;
        repeat (12) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        t_reset();
        t_fields();
        t_fsm();
        t_sleep();
        t_bus();
        report_and_stop();
    end
endmodule
`default_nettype wire
